// File: hdl/rtcflg_top.sv
// Flags/control register, century byte, alarm and time registers
// Assumes single-cycle strobes; read data valid the cycle after
// How it works
// - Alarm flag sets when unmasked time fields start to equal alarm values; not writable
// - Reading the flags register clears the alarm flag; reset clears it
// - Writing R to one while it is zero freezes holding registers with the current time
// - Writing R to zero lets holding registers follow the counters again
// - R bit is zero after reset
// - Each alarm byte holds packed-decimal value and a mask bit in bit 7
`timescale 1ns/1ps
`default_nettype none
`include "rtcflg_consts.svh"
module rtcflg_top
	import rtcflg_pkg::*;
(
	input wire logic sys_clk, // 20 MHz clock
	input wire logic rst, // Async reset, active high
	input wire logic [`RTCFLG_ADDR_W-1:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_stb, // Write strobe
	input wire logic rd_stb, // Read strobe
	input wire logic power_low, // Supply under switch-over level
	input wire logic watchdog_expired, // Watchdog event pulse
	input wire logic osc_failed, // Oscillator fail event pulse
	output logic [7:0] rdata, // Read data, cycle after strobe
	output logic cal_out_en, // Calibration output enable
	output logic alarm_flag_out // Alarm flag level
);
	// Register state
	logic wdog_flag_r, wdog_flag_nxt, alm_flag_r, alm_flag_nxt;
	logic pwr_flag_r, pwr_flag_nxt, osc_r, osc_nxt;
	logic cal_r, cal_nxt, w_r, w_nxt, rs_r, rs_nxt;
	rtcflg_byte_type cent_r, cent_nxt, rdata_r, rdata_nxt;
	rtcflg_time_type alarm_r, alarm_nxt, cnt_r, cnt_nxt, hold_r, hold_nxt, base_r, base_nxt;
	rtcflg_wstate_type st_r, st_nxt;
	logic [24:0] tick_r, tick_nxt;
	logic hit_q_r, hit_q_nxt;
	rtcflg_match_if mif();

	rtcflg_match u_match (
		.m(mif.cmp)
	);
	assign mif.now = cnt_r;
	assign mif.alarm = alarm_r;

	// Packed-decimal increment with wrap limit
	function automatic rtcflg_byte_type bcd_inc(input rtcflg_byte_type v,
		input rtcflg_byte_type lim);
		rtcflg_byte_type r;
		if (v >= lim) begin
			r = 8'h00;
		end else if (v[3:0] == 4'h9) begin
			r = {v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction : bcd_inc

	// Decode used for both read and write
	function automatic logic hit_addr(input logic [`RTCFLG_ADDR_W-1:0] a,
		input logic [`RTCFLG_ADDR_W-1:0] o);
		return a == o;
	endfunction : hit_addr

	logic flags_rd;
	assign flags_rd = rd_stb & hit_addr(addr, `RTCFLG_OFS_FLAGS);

	// Next-state for flags, control, registers and counters
	always_comb begin
		wdog_flag_nxt = wdog_flag_r;
		alm_flag_nxt = alm_flag_r;
		pwr_flag_nxt = pwr_flag_r;
		osc_nxt = osc_r;
		cal_nxt = cal_r;
		w_nxt = w_r;
		rs_nxt = rs_r;
		cent_nxt = cent_r;
		alarm_nxt = alarm_r;
		base_nxt = base_r;
		cnt_nxt = cnt_r;
		hold_nxt = hold_r;
		st_nxt = st_r;
		tick_nxt = tick_r;
		rdata_nxt = 8'h00;
		hit_q_nxt = mif.hit;
		// Read-clear first so a same-cycle event still sets
		if (flags_rd) begin
			alm_flag_nxt = 1'b0;
			pwr_flag_nxt = 1'b0;
			wdog_flag_nxt = 1'b0;
		end
		// Only the match edge sets, so one match raises one flag
		if (mif.hit & ~hit_q_r) begin
			alm_flag_nxt = 1'b1;
		end
		if (power_low) begin
			pwr_flag_nxt = 1'b1;
		end
		if (watchdog_expired) begin
			wdog_flag_nxt = 1'b1;
		end
		if (osc_failed) begin
			osc_nxt = 1'b1;
		end
		// Timekeeping: seconds tick, halted while the write window is open
		if (st_r == RTCFLG_RUN) begin
			if (tick_r == 25'(`RTCFLG_SEC_CYC - 1)) begin
				tick_nxt = 25'h0;
				cnt_nxt[0] = bcd_inc(cnt_r[0], 8'h59);
				if (cnt_r[0] == 8'h59) begin
					cnt_nxt[1] = bcd_inc(cnt_r[1], 8'h59);
					if (cnt_r[1] == 8'h59) begin
						cnt_nxt[2] = bcd_inc(cnt_r[2], 8'h23);
						if (cnt_r[2] == 8'h23) begin
							cnt_nxt[3] = bcd_inc(cnt_r[3], 8'h31);
						end
					end
				end
			end else begin
				tick_nxt = tick_r + 25'h1;
			end
		end
		// Write port
		if (wr_stb) begin
			case (addr)
				`RTCFLG_OFS_FLAGS: begin
					// Event beats a same-cycle clearing write
					osc_nxt = (osc_r & wdata[`RTCFLG_BIT_OSC]) | osc_failed;
					cal_nxt = wdata[`RTCFLG_BIT_CAL];
					w_nxt = wdata[`RTCFLG_BIT_W];
					rs_nxt = wdata[`RTCFLG_BIT_R];
					if (wdata[`RTCFLG_BIT_R] & ~rs_r) begin
						hold_nxt = cnt_r;
					end
				end
				`RTCFLG_OFS_CENT: cent_nxt = wdata;
				`RTCFLG_OFS_ASEC: alarm_nxt[0] = wdata;
				`RTCFLG_OFS_AMIN: alarm_nxt[1] = wdata;
				`RTCFLG_OFS_AHOUR: alarm_nxt[2] = wdata;
				`RTCFLG_OFS_ADAY: alarm_nxt[3] = wdata;
				`RTCFLG_OFS_TSEC: if (w_r) base_nxt[0] = wdata;
				`RTCFLG_OFS_TMIN: if (w_r) base_nxt[1] = wdata;
				`RTCFLG_OFS_THOUR: if (w_r) base_nxt[2] = wdata;
				`RTCFLG_OFS_TDAY: if (w_r) base_nxt[3] = wdata;
				default: begin
				end
			endcase
		end
		// Write-window sequencer
		case (st_r)
			RTCFLG_RUN: if (w_nxt) st_nxt = RTCFLG_WOPEN;
			RTCFLG_WOPEN: if (~w_r) st_nxt = RTCFLG_LOAD;
			RTCFLG_LOAD: begin
				cnt_nxt = base_r;
				tick_nxt = 25'h0;
				st_nxt = RTCFLG_RUN;
			end
			default: st_nxt = RTCFLG_RUN;
		endcase
		// Holding registers track unless frozen
		if (~rs_r & ~(wr_stb & hit_addr(addr, `RTCFLG_OFS_FLAGS) & wdata[`RTCFLG_BIT_R])) begin
			hold_nxt = cnt_nxt;
		end
		// Read port; time reads come from holding registers
		if (rd_stb) begin
			case (addr)
				`RTCFLG_OFS_FLAGS: begin
					rdata_nxt = {wdog_flag_r, alm_flag_r, pwr_flag_r, osc_r,
						1'b0, cal_r, w_r, rs_r};
				end
				`RTCFLG_OFS_CENT: rdata_nxt = cent_r;
				`RTCFLG_OFS_ASEC: rdata_nxt = alarm_r[0];
				`RTCFLG_OFS_AMIN: rdata_nxt = alarm_r[1];
				`RTCFLG_OFS_AHOUR: rdata_nxt = alarm_r[2];
				`RTCFLG_OFS_ADAY: rdata_nxt = alarm_r[3];
				`RTCFLG_OFS_TSEC: rdata_nxt = hold_r[0];
				`RTCFLG_OFS_TMIN: rdata_nxt = hold_r[1];
				`RTCFLG_OFS_THOUR: rdata_nxt = hold_r[2];
				`RTCFLG_OFS_TDAY: rdata_nxt = hold_r[3];
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// State registers; reset is power up
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wdog_flag_r <= 1'b0;
			alm_flag_r <= 1'b0;
			pwr_flag_r <= 1'b0;
			osc_r <= 1'b0;
			cal_r <= 1'b0;
			w_r <= 1'b0;
			rs_r <= 1'b0;
			cent_r <= `RTCFLG_CENT_RST;
			alarm_r <= {4{`RTCFLG_ALARM_RST}};
			base_r <= '0;
			cnt_r <= '0;
			hold_r <= '0;
			st_r <= RTCFLG_RUN;
			tick_r <= 25'h0;
			rdata_r <= 8'h00;
			// Matches its idle level: all alarm fields masked after reset
			hit_q_r <= 1'b1;
		end else begin
			wdog_flag_r <= wdog_flag_nxt;
			alm_flag_r <= alm_flag_nxt;
			pwr_flag_r <= pwr_flag_nxt;
			osc_r <= osc_nxt;
			cal_r <= cal_nxt;
			w_r <= w_nxt;
			rs_r <= rs_nxt;
			cent_r <= cent_nxt;
			alarm_r <= alarm_nxt;
			base_r <= base_nxt;
			cnt_r <= cnt_nxt;
			hold_r <= hold_nxt;
			st_r <= st_nxt;
			tick_r <= tick_nxt;
			rdata_r <= rdata_nxt;
			hit_q_r <= hit_q_nxt;
		end
	end

	assign rdata = rdata_r;
	assign cal_out_en = cal_r;
	assign alarm_flag_out = alm_flag_r;
endmodule : rtcflg_top
`default_nettype wire

// File: include/rtcflg_consts.svh
// Constants for the clock flags and control register block
// Assumes byte-wide register port and a 20 MHz system clock
`ifndef RTCFLG_CONSTS_SVH
`define RTCFLG_CONSTS_SVH
`define RTCFLG_ADDR_W 17
`define RTCFLG_OFS_FLAGS 17'h1fff0
`define RTCFLG_OFS_CENT 17'h1fff1
`define RTCFLG_OFS_ASEC 17'h1fff2
`define RTCFLG_OFS_AMIN 17'h1fff3
`define RTCFLG_OFS_AHOUR 17'h1fff4
`define RTCFLG_OFS_ADAY 17'h1fff5
`define RTCFLG_OFS_TSEC 17'h1fff6
`define RTCFLG_OFS_TMIN 17'h1fff7
`define RTCFLG_OFS_THOUR 17'h1fff8
`define RTCFLG_OFS_TDAY 17'h1fff9
`define RTCFLG_BIT_WDOG 7
`define RTCFLG_BIT_ALM 6
`define RTCFLG_BIT_PWR 5
`define RTCFLG_BIT_OSC 4
`define RTCFLG_BIT_CAL 2
`define RTCFLG_BIT_W 1
`define RTCFLG_BIT_R 0
`define RTCFLG_BIT_MASK 7
`define RTCFLG_CENT_RST 8'h00
`define RTCFLG_ALARM_RST 8'h80
`define RTCFLG_CLK_HZ 20000000
`define RTCFLG_SEC_CYC 20000000
`endif

// File: include/rtcflg_pkg.sv
// Types for the clock flags and control register block
// Assumes nothing beyond the constants header
package rtcflg_pkg;
	typedef logic [7:0] rtcflg_byte_type;
	typedef logic [3:0][7:0] rtcflg_time_type; // Day, hour, minute, second
	typedef enum logic [2:0] {
		RTCFLG_RUN = 3'h1,
		RTCFLG_WOPEN = 3'h2,
		RTCFLG_LOAD = 3'h4
	} rtcflg_wstate_type;
endpackage : rtcflg_pkg

// File: include/rtcflg_match_if.sv
// Interface carrying time and alarm values to the matcher
// Assumes one driver per modport side
`timescale 1ns/1ps
`default_nettype none
interface rtcflg_match_if;
	import rtcflg_pkg::*;
	rtcflg_time_type now;
	rtcflg_time_type alarm;
	logic hit;
	modport ctl (output now, output alarm, input hit);
	modport cmp (input now, input alarm, output hit);
endinterface : rtcflg_match_if
`default_nettype wire

// File: hdl/rtcflg_match.sv
// Alarm comparator over four masked packed-decimal fields
// Assumes alarm bytes carry the mask in bit 7
`timescale 1ns/1ps
`default_nettype none
`include "rtcflg_consts.svh"
module rtcflg_match
	import rtcflg_pkg::*;
(
	rtcflg_match_if.cmp m // Time and alarm values
);
	logic [3:0] field_ok;
	genvar g;
	// A masked field always agrees
	generate
		for (g = 0; g < 4; g++) begin : g_fld
			assign field_ok[g] = m.alarm[g][`RTCFLG_BIT_MASK] |
				(m.alarm[g][6:0] == m.now[g][6:0]);
		end
	endgenerate
	assign m.hit = &field_ok;
endmodule : rtcflg_match
`default_nettype wire

// File: tb/rtcflg_monitor.sv
// Checker on the flags register block ports
// Assumes it is bound into rtcflg_top
`timescale 1ns/1ps
`default_nettype none
`include "rtcflg_consts.svh"
module rtcflg_monitor (
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic [`RTCFLG_ADDR_W-1:0] addr, // Address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr_stb, // Write
	input wire logic rd_stb, // Read
	input wire logic power_low, // Supply low
	input wire logic [7:0] rdata, // Read data
	input wire logic cal_out_en // Cal enable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Bus cycles on the flags and century bytes
	sequence s_rfl; rd_stb && addr == `RTCFLG_OFS_FLAGS; endsequence
	sequence s_wfl; wr_stb && addr == `RTCFLG_OFS_FLAGS; endsequence
	sequence s_wce; wr_stb && addr == `RTCFLG_OFS_CENT; endsequence
	sequence s_rce; rd_stb && addr == `RTCFLG_OFS_CENT; endsequence
	rdata_idle_a: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata not idle");
	pwr_set_a: assert property (power_low ##1 s_rfl |=> rdata[5])
		else $error("power fail flag missing");
	// Gap cycle kept quiet so nothing can set the flag again
	pwr_clear_a: assert property ((rd_stb && addr == `RTCFLG_OFS_FLAGS && !power_low)
		##1 (!power_low && !rd_stb) ##1 s_rfl |=> !rdata[5]) else $error("power fail kept");
	flag_rw_a: assert property (s_wfl ##1 s_rfl |=> rdata[1:0] == $past(wdata[1:0], 2))
		else $error("control bits wrong");
	cal_out_a: assert property (s_wfl ##1 !wr_stb ##1 !wr_stb |-> cal_out_en == $past(wdata[2], 2))
		else $error("cal enable wrong");
	cent_rw_a: assert property (s_wce ##1 s_rce |=> rdata == $past(wdata, 2))
		else $error("century wrong");
	unmapped_a: assert property (rd_stb && (addr < `RTCFLG_OFS_FLAGS || addr > `RTCFLG_OFS_TDAY)
		|=> rdata == 8'h00) else $error("unmapped read not zero");
	zero_bit_a: assert property (s_rfl |=> !rdata[3]) else $error("flags bit 3 set");
endmodule : rtcflg_monitor
bind rtcflg_top rtcflg_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .power_low(power_low),
	.rdata(rdata), .cal_out_en(cal_out_en));
`default_nettype wire

// File: tb/rtcflg_host.sv
// Host processor model on the byte-wide register port
// Assumes tasks are called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module rtcflg_host (
	input wire logic sys_clk, // Clock
	output logic [16:0] addr, // Address
	output logic [7:0] wdata, // Write data
	output logic wr_stb, // Write
	output logic rd_stb, // Read
	input wire logic [7:0] rdata // Read data
);
	// Quiet bus at time zero
	initial begin
		addr = 17'h00000;
		wdata = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end
	// Strobe left up so a second access may follow with no gap
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	// Data taken only in the cycle after the strobe; stale write data scrambled
	task automatic rd(input logic [16:0] a, output logic [7:0] d);
		addr <= a;
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		wdata <= ~wdata;
		@(posedge sys_clk);
		d = rdata;
	endtask : rd
endmodule : rtcflg_host
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the flags register block
// Assumes the seconds tick never comes within the run
`timescale 1ns/1ps
`default_nettype none
`include "rtcflg_consts.svh"
module testbench;
	localparam logic [16:0] FL = `RTCFLG_OFS_FLAGS;
	localparam logic [16:0] TS = `RTCFLG_OFS_TSEC;
	localparam logic [16:0] AS = `RTCFLG_OFS_ASEC;
	localparam logic [16:0] CE = `RTCFLG_OFS_CENT;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic power_low, watchdog_expired, osc_failed;
	logic [16:0] addr;
	logic [7:0] wdata, rdata, v;
	logic wr_stb, rd_stb, cal_out_en, alarm_flag_out;
	int failures = 0;
	int n_checks = 0;
	always #25 sys_clk = ~sys_clk;
	rtcflg_top u_rtcflg_top (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .power_low(power_low),
		.watchdog_expired(watchdog_expired), .osc_failed(osc_failed), .rdata(rdata),
		.cal_out_en(cal_out_en), .alarm_flag_out(alarm_flag_out));
	rtcflg_host u_host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [16:0] a, input logic [7:0] exp);
		logic [7:0] r;
		u_host.rd(a, r);
		chk(r, exp);
	endtask : rchk
	// Expected flags byte from its fields; bit 3 always reads zero
	function automatic logic [7:0] exp_flags(input logic wd, input logic al, input logic pw,
		input logic os, input logic [2:0] ctl);
		return {wd, al, pw, os, 1'b0, ctl};
	endfunction : exp_flags
	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out
	// Hang guard, far beyond the roughly 90 cycles needed
	initial begin
		#2000000;
		failures++;
		close_out();
	end
	initial begin
		{power_low, watchdog_expired, osc_failed} = 3'b000;
		v = $urandom(32'h75e7);
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Seconds alarm armed off time zero so nothing matches yet
		u_host.wr(AS, 8'h59);
		u_host.rd(FL, v);
		chk(v, 8'h00);
		rchk(FL, 8'h00);
		rchk(CE, 8'h00);
		repeat (4) begin
			v = $urandom;
			u_host.wr(CE, v);
			rchk(CE, v);
		end
		u_host.wr(17'h1fffa, v);
		rchk(17'h1fffa, 8'h00);
		// Event flags: read clears two, the oscillator one needs a write
		{power_low, watchdog_expired, osc_failed} <= 3'b111;
		@(posedge sys_clk);
		{power_low, watchdog_expired, osc_failed} <= 3'b000;
		rchk(FL, exp_flags(1'b1, 1'b0, 1'b1, 1'b1, 3'h0));
		rchk(FL, exp_flags(1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
		// A new oscillator event in the clearing write's cycle survives it
		osc_failed <= 1'b1;
		u_host.wr(FL, 8'h00);
		osc_failed <= 1'b0;
		rchk(FL, exp_flags(1'b0, 1'b0, 1'b0, 1'b1, 3'h0));
		u_host.wr(FL, 8'h00);
		rchk(FL, 8'h00);
		// Time bytes refuse writes until the write window opens
		u_host.wr(TS, 8'h33);
		rchk(TS, 8'h00);
		u_host.wr(FL, 8'h02);
		u_host.wr(TS, 8'h58);
		u_host.wr(FL, 8'h00);
		rchk(FL, 8'h00);
		rchk(TS, 8'h58);
		u_host.wr(AS, 8'h58);
		rchk(AS, 8'h58);
		chk({7'h00, alarm_flag_out}, 8'h01);
		rchk(FL, 8'h40);
		rchk(FL, 8'h00);
		u_host.wr(FL, 8'h40);
		rchk(FL, 8'h00);
		// Minutes still match; masking the seconds field completes the match
		u_host.wr(AS, 8'h30);
		u_host.wr(`RTCFLG_OFS_AMIN, 8'h00);
		rchk(FL, 8'h00);
		u_host.wr(AS, 8'hb0);
		rchk(AS, 8'hb0);
		rchk(FL, 8'h40);
		// New base time loaded under a frozen snapshot stays hidden
		u_host.wr(FL, 8'h01);
		u_host.wr(FL, 8'h03);
		u_host.wr(TS, 8'h11);
		u_host.wr(FL, 8'h01);
		rchk(FL, 8'h01);
		rchk(TS, 8'h58);
		u_host.wr(FL, 8'h00);
		rchk(FL, 8'h00);
		rchk(TS, 8'h11);
		// Second power-up in mid-run: snapshot and calibration bits must drop
		u_host.wr(FL, 8'h05);
		rchk(FL, exp_flags(1'b0, 1'b0, 1'b0, 1'b0, 3'h5));
		chk({7'h00, cal_out_en}, 8'h01);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk({7'h00, cal_out_en}, 8'h00);
		rchk(FL, 8'h00);
		close_out();
	end
endmodule : testbench
`default_nettype wire
